// file: logic/ser_enq_responder.v
// Slave engine for addressed read enquiries on a multidrop ASCII link
// Notes on behaviour
// - STX 02, ETX 03, EOT 04, ENQ 05.
// - After EOT, next four characters are address.
// - Selected only if all four ids match.
// - ENQ after mnemonic ends a read frame.
// - After enquiry, selected device becomes transmitter.
// - Reply STX, mnemonic, value, ETX, check.
// - Value uses shortest possible string.
// - Check is XOR of mnemonic through ETX.
// - Unknown mnemonic answered by single EOT.
// - Host then sends NAK, ACK or EOT.
// - NAK resends same parameter, no readdressing.
// - ACK sends next parameter in list.
// - EOT deselects; listen for next address.
// - Silent on address mismatch or character error.
// - Word value is '>' plus hex digits.
`timescale 1ns/1ns
`include "ser_defines.vh"
module ser_enq_responder (
	// Clock and reset
	input wire clock,
	input wire rstn,
	// Character receiver
	input wire [7:0] rx_data,
	input wire rx_valid,
	input wire rx_error,
	// Character transmitter
	output reg [7:0] tx_data,
	output wire tx_valid,
	input wire tx_ready,
	// Address straps
	input wire [7:0] group_id_char,
	input wire [7:0] unit_id_char,
	// Parameter store request
	output reg param_req,
	output reg param_next,
	output reg [7:0] mnemonic_char_first,
	output reg [7:0] mnemonic_char_second,
	// Parameter store answer
	input wire param_ack,
	input wire param_known,
	input wire [7:0] param_char_first,
	input wire [7:0] param_char_second,
	input wire [15:0] param_value,
	// Status
	output wire selected
);
	reg [3:0] state;
	reg [3:0] tx_pos;
	reg [7:0] bcc;
	reg [15:0] value;
	reg addr_miss;
	reg char_err;
	wire [7:0] group_sync;
	wire [7:0] unit_sync;
	wire [2:0] ndig;
	wire [3:0] pos_etx;
	wire [3:0] pos_bcc;
	wire tx_fire;
	wire rx_eot;
	reg [7:0] next_bcc;
	reg [7:0] next_char;

	// Straps come from pins, so they cross into the clock domain first
	ser_sync #(.WIDTH(8)) u_group_sync (
		.clock(clock),
		.rstn(rstn),
		.pin_in(group_id_char),
		.sync_out(group_sync)
	);
	ser_sync #(.WIDTH(8)) u_unit_sync (
		.clock(clock),
		.rstn(rstn),
		.pin_in(unit_id_char),
		.sync_out(unit_sync)
	);

	assign ndig = (value[15:12] != 4'h0) ? `SER_DIGITS_4 :
		(value[11:8] != 4'h0) ? `SER_DIGITS_3 :
		(value[7:4] != 4'h0) ? `SER_DIGITS_2 : `SER_DIGITS_1;
	assign pos_etx = `SER_POS_DIGIT0 + {1'b0, ndig};
	assign pos_bcc = pos_etx + `SER_POS_BCC_AFTER_ETX;

	assign tx_valid = (state == `SER_ST_REPLY) || (state == `SER_ST_REPLY_EOT);
	assign tx_fire = tx_valid && tx_ready;
	assign selected = (state == `SER_ST_FETCH) || (state == `SER_ST_REPLY) ||
		(state == `SER_ST_HOLD);
	assign rx_eot = rx_valid && !rx_error && (rx_data == `SER_EOT);

	function [7:0] hex_char;
		input [3:0] nib;
		begin
			if (nib < `SER_NIBBLE_TEN)
				hex_char = `SER_ASCII_ZERO + {4'h0, nib};
			else
				hex_char = `SER_ASCII_ALPHA_BASE + {4'h0, nib};
		end
	endfunction

	// Next reply character, chosen one position ahead so tx_data is a flop
	always @* begin : next_char_sel
		reg [3:0] shift;
		shift = pos_etx - tx_pos - 4'h2;
		next_bcc = (tx_pos == `SER_POS_STX) ? bcc : (bcc ^ tx_data);
		if (tx_pos + 4'h1 == `SER_POS_C1) begin
			next_char = mnemonic_char_first;
		end else if (tx_pos + 4'h1 == `SER_POS_C2) begin
			next_char = mnemonic_char_second;
		end else if (tx_pos + 4'h1 == `SER_POS_PREFIX) begin
			next_char = `SER_WORD_PREFIX;
		end else if (tx_pos + 4'h1 == pos_etx) begin
			next_char = `SER_ETX;
		end else if (tx_pos + 4'h1 == pos_bcc) begin
			// Running check stops at the last digit, so fold in the ETX now on tx_data
			next_char = next_bcc;
		end else begin
			case (shift[1:0])
				2'h3: next_char = hex_char(value[15:12]);
				2'h2: next_char = hex_char(value[11:8]);
				2'h1: next_char = hex_char(value[7:4]);
				default: next_char = hex_char(value[3:0]);
			endcase
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= `SER_ST_IDLE;
			tx_pos <= `SER_POS_STX;
			tx_data <= 8'h00;
			bcc <= 8'h00;
			value <= 16'h0000;
			addr_miss <= 1'b0;
			char_err <= 1'b0;
			param_req <= 1'b0;
			param_next <= 1'b0;
			mnemonic_char_first <= 8'h00;
			mnemonic_char_second <= 8'h00;
		end else begin
			param_req <= 1'b0;
			if (rx_eot && state != `SER_ST_FETCH && state != `SER_ST_REPLY &&
					state != `SER_ST_REPLY_EOT) begin
				state <= `SER_ST_GROUP_A;
				addr_miss <= 1'b0;
				char_err <= 1'b0;
			end else begin
				case (state)
					`SER_ST_IDLE: begin
						state <= `SER_ST_IDLE;
					end
					`SER_ST_GROUP_A, `SER_ST_GROUP_B: begin
						if (rx_valid) begin
							if (rx_data != group_sync)
								addr_miss <= 1'b1;
							if (rx_error)
								char_err <= 1'b1;
							state <= state + 4'h1;
						end
					end
					`SER_ST_UNIT_A, `SER_ST_UNIT_B: begin
						if (rx_valid) begin
							if (rx_data != unit_sync)
								addr_miss <= 1'b1;
							if (rx_error)
								char_err <= 1'b1;
							state <= state + 4'h1;
						end
					end
					`SER_ST_MNEM_A: begin
						if (rx_valid) begin
							mnemonic_char_first <= rx_data;
							if (rx_error)
								char_err <= 1'b1;
							state <= `SER_ST_MNEM_B;
						end
					end
					`SER_ST_MNEM_B: begin
						if (rx_valid) begin
							mnemonic_char_second <= rx_data;
							if (rx_error)
								char_err <= 1'b1;
							state <= `SER_ST_WAIT_ENQ;
						end
					end
					`SER_ST_WAIT_ENQ: begin
						if (rx_valid) begin
							if (rx_data == `SER_ENQ && !rx_error && !char_err && !addr_miss) begin
								param_req <= 1'b1;
								param_next <= 1'b0;
								state <= `SER_ST_FETCH;
							end else begin
								state <= `SER_ST_IDLE;
							end
						end
					end
					`SER_ST_FETCH: begin
						if (param_ack) begin
							if (param_known) begin
								mnemonic_char_first <= param_char_first;
								mnemonic_char_second <= param_char_second;
								value <= param_value;
								tx_data <= `SER_STX;
								tx_pos <= `SER_POS_STX;
								bcc <= 8'h00;
								state <= `SER_ST_REPLY;
							end else begin
								tx_data <= `SER_EOT;
								state <= `SER_ST_REPLY_EOT;
							end
						end
					end
					`SER_ST_REPLY: begin
						if (tx_fire) begin
							if (tx_pos == pos_bcc) begin
								state <= `SER_ST_HOLD;
							end else begin
								bcc <= next_bcc;
								tx_pos <= tx_pos + 4'h1;
								tx_data <= next_char;
							end
						end
					end
					`SER_ST_REPLY_EOT: begin
						// Control handed back; wait for a fresh address
						if (tx_fire)
							state <= `SER_ST_IDLE;
					end
					`SER_ST_HOLD: begin
						// host picks NAK, ACK or EOT
						if (rx_valid) begin
							if (!rx_error && rx_data == `SER_NAK) begin
								param_req <= 1'b1;
								param_next <= 1'b0;
								state <= `SER_ST_FETCH;
							end else if (!rx_error && rx_data == `SER_ACK) begin
								param_req <= 1'b1;
								param_next <= 1'b1;
								state <= `SER_ST_FETCH;
							end else begin
								state <= `SER_ST_IDLE;
							end
						end
					end
					default: begin
						state <= `SER_ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule // ser_enq_responder

// file: inc/ser_defines.vh
// Character codes, state codes and reply positions for the enquiry responder
`ifndef SER_DEFINES_VH
`define SER_DEFINES_VH

// Framing and control characters
`define SER_STX 8'h02
`define SER_ETX 8'h03
`define SER_EOT 8'h04
`define SER_ENQ 8'h05
`define SER_ACK 8'h06
`define SER_NAK 8'h15
`define SER_WORD_PREFIX 8'h3e
`define SER_ASCII_ZERO 8'h30
`define SER_ASCII_ALPHA_BASE 8'h37
`define SER_NIBBLE_TEN 4'ha

// Parser and reply states
`define SER_ST_IDLE 4'h0
`define SER_ST_GROUP_A 4'h1
`define SER_ST_GROUP_B 4'h2
`define SER_ST_UNIT_A 4'h3
`define SER_ST_UNIT_B 4'h4
`define SER_ST_MNEM_A 4'h5
`define SER_ST_MNEM_B 4'h6
`define SER_ST_WAIT_ENQ 4'h7
`define SER_ST_FETCH 4'h8
`define SER_ST_REPLY 4'h9
`define SER_ST_REPLY_EOT 4'ha
`define SER_ST_HOLD 4'hb

// Character positions within a value reply
`define SER_POS_STX 4'h0
`define SER_POS_C1 4'h1
`define SER_POS_C2 4'h2
`define SER_POS_PREFIX 4'h3
`define SER_POS_DIGIT0 4'h4
`define SER_POS_BCC_AFTER_ETX 4'h1

// Digit counts of a word value
`define SER_DIGITS_1 3'h1
`define SER_DIGITS_2 3'h2
`define SER_DIGITS_3 3'h3
`define SER_DIGITS_4 3'h4

`endif

// file: logic/ser_sync.v
// Two-stage synchroniser for a group of static configuration pins
`timescale 1ns/1ns
module ser_sync #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire clock,
	input wire rstn,
	// Pins and synchronised copy
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage_one;

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			stage_one <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			stage_one <= pin_in;
			sync_out <= stage_one;
		end
	end
endmodule // ser_sync

// file: verification/ser_store_model.sv
// Parameter store model that answers one cycle after a lookup
`timescale 1ns/1ns
module ser_store_model (
	// Clock and reset
	input wire clock,
	input wire rstn,
	// Lookup
	input wire param_req,
	input wire param_next,
	input wire [7:0] m1,
	input wire [7:0] m2,
	input wire [15:0] val,
	// Answer
	output reg param_ack,
	output reg param_known,
	output reg [7:0] pc1,
	output reg [7:0] pc2,
	output reg [15:0] pv
);
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			param_ack <= 1'b0;
		end else begin
			param_ack <= param_req;
		end
	end
	// Scroll steps the second char; a leading Z is unknown
	always @(posedge clock) begin
		param_known <= (m1 != 8'h5a);
		pc1 <= m1;
		pc2 <= m2 + {7'h00, param_next};
		pv <= val;
	end
endmodule // ser_store_model

// file: verification/ser_enq_responder_sva.sv
// Port checker for the enquiry responder
`timescale 1ns/1ns
module ser_enq_responder_sva (
	// Clock and reset
	input wire clock,
	input wire rstn,
	// Characters
	input wire [7:0] rx_data,
	input wire rx_valid,
	input wire rx_error,
	input wire [7:0] tx_data,
	input wire tx_valid,
	input wire tx_ready,
	// Store and status
	input wire param_req,
	input wire param_next,
	input wire param_ack,
	input wire param_known,
	input wire selected
);
	reg [7:0] acc;
	reg etx_seen;
	wire take = tx_valid && tx_ready;
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			acc <= 8'h00;
			etx_seen <= 1'b0;
		end else if (take) begin
			acc <= (tx_data == 8'h02) ? 8'h00 : acc ^ tx_data;
			etx_seen <= (tx_data == 8'h03) && !etx_seen;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	a_req_pulse: assert property (param_req |=> !param_req)
		else $error("lookup held too long");
	a_req_cause: assert property (param_req |-> $past(rx_valid && !rx_error
		&& (rx_data == 8'h05 || rx_data == 8'h15 || rx_data == 8'h06))) else $error("stray lookup");
	a_next_kind: assert property (param_req |-> param_next == ($past(rx_data) == 8'h06))
		else $error("wrong lookup kind");
	a_reply_start: assert property (param_ack && param_known && selected
		|=> tx_valid && tx_data == 8'h02) else $error("reply not opened");
	a_unknown_eot: assert property (param_ack && !param_known && selected
		|=> tx_valid && tx_data == 8'h04) else $error("no single end char");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("char dropped");
	a_err_silent: assert property (rx_valid && rx_error && !selected |=> !param_req)
		else $error("errored char acted on");
	a_bcc_match: assert property (take && etx_seen |-> tx_data == acc)
		else $error("bad check char");
	a_idle_quiet: assert property (!selected && !tx_valid |=> !tx_valid)
		else $error("talk while idle");
	c_scroll: cover property (param_req && param_next);
	c_unknown: cover property (param_ack && !param_known);
	c_check: cover property (take && etx_seen);
endmodule // ser_enq_responder_sva
bind ser_enq_responder ser_enq_responder_sva u_sva (.clock(clock), .rstn(rstn),
	.rx_data(rx_data), .rx_valid(rx_valid), .rx_error(rx_error), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .param_req(param_req),
	.param_next(param_next), .param_ack(param_ack), .param_known(param_known),
	.selected(selected));

// file: verification/ser_enq_responder_tb.sv
// Self-checking bench for the enquiry responder
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t value mismatch", $time); end end
module ser_enq_responder_tb;
	logic clock = 1'b0, rstn = 1'b0, rx_valid = 1'b0, rx_error = 1'b0, tx_ready = 1'b0;
	logic [7:0] rx_data = 8'h00, grp = 8'h30, unt = 8'h30, tx_data, m1, m2, pc1, pc2;
	logic [15:0] val = 16'h0000, pv;
	logic tx_valid, param_req, param_next, param_ack, param_known, selected;
	logic [7:0] exp_q[$];
	int n_fail = 0, tests_run = 0, cyc = 0;
	initial forever #5 clock = ~clock;
	ser_enq_responder u_dut (.clock(clock), .rstn(rstn), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_error(rx_error), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .group_id_char(grp), .unit_id_char(unt), .param_req(param_req),
		.param_next(param_next), .mnemonic_char_first(m1), .mnemonic_char_second(m2),
		.param_ack(param_ack), .param_known(param_known), .param_char_first(pc1),
		.param_char_second(pc2), .param_value(pv), .selected(selected));
	ser_store_model u_store (.clock(clock), .rstn(rstn), .param_req(param_req),
		.param_next(param_next), .m1(m1), .m2(m2), .val(val), .param_ack(param_ack),
		.param_known(param_known), .pc1(pc1), .pc2(pc2), .pv(pv));
	task finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			finish_test();
		end else if (rstn && tx_valid && tx_ready) begin
			if (exp_q.size() == 0) begin
				n_fail++;
				$display("[ERR] %0t unexpected char", $time);
			end else
				`CHK(tx_data, exp_q.pop_front())
		end
	end
	// Random stalls on the transmitter
	always @(negedge clock) tx_ready <= ($urandom % 4) != 0;
	task send(input logic [7:0] f[$], input int ep);
		for (int i = 0; i < f.size(); i++) begin
			@(negedge clock);
			rx_data = f[i];
			rx_valid = 1'b1;
			rx_error = (i == ep);
		end
		@(negedge clock);
		rx_valid = 1'b0;
		rx_error = 1'b0;
	endtask
	// host frame: end char, ids twice, mnemonic, enquiry
	task rd(input logic [7:0] g2, u2, c1, c2, input int ep);
		send('{8'h04, grp, g2, unt, u2, c1, c2, 8'h05}, ep);
	endtask
	task reply(input logic [7:0] c1, c2, input logic [15:0] v);
		logic [7:0] b, ch;
		int n;
		n = 4;
		while (n > 1 && v[4*n-1 -: 4] == 4'h0)
			n--;
		b = c1 ^ c2 ^ 8'h3e ^ 8'h03;
		exp_q.push_back(8'h02);
		exp_q.push_back(c1);
		exp_q.push_back(c2);
		exp_q.push_back(8'h3e);
		for (int i = n - 1; i >= 0; i--) begin
			ch = (v[4*i +: 4] < 4'ha) ? 8'h30 + v[4*i +: 4] : 8'h37 + v[4*i +: 4];
			b = b ^ ch;
			exp_q.push_back(ch);
		end
		exp_q.push_back(8'h03);
		exp_q.push_back(b);
	endtask
	task drain(input string name);
		for (int i = 0; i < 400 && exp_q.size() != 0; i++)
			@(negedge clock);
		repeat (12) @(negedge clock);
		`CHK(exp_q.size(), 0)
		$display("test %s done", name);
	endtask
	logic [15:0] vals[4] = '{16'h0000, 16'h000f, 16'h0a00, 16'hffff};
	initial begin
		void'($urandom(75581));
		grp = 8'h30 + 8'($urandom % 10);
		unt = 8'h41 + 8'($urandom % 10);
		repeat (12) @(negedge clock);
		rstn = 1'b1;
		repeat (3) @(negedge clock);
		val = 16'($urandom);
		reply(8'h49, 8'h49, val);
		rd(grp, unt, 8'h49, 8'h49, -1);
		drain("read");
		`CHK(selected, 1'b1)
		val = 16'($urandom);
		reply(8'h49, 8'h49, val);
		send('{8'h15}, -1);
		drain("repeat");
		val = 16'($urandom);
		reply(8'h49, 8'h4a, val);
		send('{8'h06}, -1);
		drain("scroll");
		send('{8'h04, 8'h15}, -1);
		drain("end");
		`CHK(selected, 1'b0)
		foreach (vals[k]) begin
			val = vals[k];
			reply(8'h30, 8'h31 + 8'(k), val);
			rd(grp, unt, 8'h30, 8'h31 + 8'(k), -1);
			drain("value");
		end
		exp_q.push_back(8'h04);
		rd(grp, unt, 8'h5a, 8'h5a, -1);
		// Let the lone EOT go out so the ACK lands while idle
		repeat (20) @(negedge clock);
		send('{8'h06}, -1);
		drain("unknown");
		rd(grp, unt ^ 8'h01, 8'h49, 8'h49, -1);
		rd(grp + 8'h01, unt, 8'h49, 8'h49, -1);
		rd(grp, unt, 8'h49, 8'h49, 7);
		rd(grp, unt, 8'h49, 8'h49, 2);
		drain("silent");
		reply(8'h49, 8'h49, val);
		send('{8'h04, grp, grp, 8'h04, grp, grp, unt, unt, 8'h49, 8'h49, 8'h05}, -1);
		drain("restart");
		finish_test();
	end
endmodule // ser_enq_responder_tb
